//--- logic/fams_top.v
// command decoder for status write, address mode, upper bank and info register
`timescale 1ns/100ps
`default_nettype none
`include "fams_consts.vh"
module fams_top #(
  parameter TW_CYCLES = `FAMS_TW_US * `FAMS_MCLK_MHZ, // self-timed write length
  parameter [7:0] QIO_RST_OP = 8'hFF, // quad-io reset opcode
  parameter [7:0] PROG_OP = 8'h02, // page program opcode
  parameter [7:0] SECT_ER_OP = 8'h20, // sector erase opcode
  parameter [7:0] BLK_ER_OP = 8'hD8, // block erase opcode
  parameter [7:0] CHIP_ER_OP = 8'hC7 // chip erase opcode
) (
  input wire mclk, // 25 MHz block clock
  input wire resetn, // async power-on reset
  input wire cs_n, // chip select pin
  input wire sclk, // serial clock pin
  input wire si, // serial data in pin
  input wire wp_n, // write-guard pin
  input wire otp_mode, // otp sector mode active
  input wire prog_fail_evt, // array reports failed program
  input wire prog_prot_hit, // program hit protected main area
  input wire prog_otp_hit, // program aimed at otp sector
  input wire erase_fail_evt, // array reports failed erase
  input wire erase_prot_hit, // erase hit protected main area
  input wire erase_otp_hit, // erase aimed at otp sector
  output reg so, // serial data out
  output reg so_oe, // so driven while high
  output reg busy_flag, // self-timed cycle running
  output reg write_unlock_latch, // writes allowed
  output reg wide_addr, // 32-bit address mode
  output reg upper_bank_flag, // address bit 24 forced high
  output reg otp_lock, // otp sector sealed
  output reg [3:0] protect_level_field, // block protect level
  output reg status_guard_bit, // status guard bit
  output reg hardware_guard_mode // status writes locked
);
  // ----------------------------------------------------------------
  // states and widths
  // ----------------------------------------------------------------
  localparam [3:0] ST_OPC = 4'b0001;
  localparam [3:0] ST_DATA = 4'b0010;
  localparam [3:0] ST_READ = 4'b0100;
  localparam [3:0] ST_IGN = 4'b1000;
  localparam CW = 20;
  localparam integer TW_LAST_INT = TW_CYCLES - 1;
  localparam [CW-1:0] TW_LAST = TW_LAST_INT[CW-1:0];

  reg [3:0] state;
  reg [4:0] bit_cnt;
  reg [7:0] shift_in;
  reg [7:0] read_sel;
  reg [7:0] sh_out;
  reg [2:0] rd_cnt;
  reg [CW-1:0] tw_cnt;
  reg status_s6;
  reg prog_fail;
  reg erase_fail;
  reg [2:0] sclk_q;
  reg [2:0] cs_q;
  reg [1:0] si_q;
  reg [1:0] wp_q;
  wire sclk_rise;
  wire sclk_fall;
  wire cs_rise;
  wire cs_low;
  wire [7:0] opc;
  wire [7:0] info_val;
  wire [7:0] stat_val;
  wire wr_ok;
  wire op_start;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // two flops per pin, third flop only for edge finding
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclk_q <= 3'h0;
      cs_q <= 3'h7;
      si_q <= 2'h0;
      wp_q <= 2'h3;
    end
    else
    begin
      sclk_q <= {sclk_q[1:0], sclk};
      cs_q <= {cs_q[1:0], cs_n};
      si_q <= {si_q[0], si};
      wp_q <= {wp_q[0], wp_n};
    end
  end

  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign sclk_fall = ~sclk_q[1] & sclk_q[2];
  assign cs_rise = cs_q[1] & ~cs_q[2];
  assign cs_low = ~cs_q[1];
  // opcode complete on the eighth rising edge
  assign opc = {shift_in[6:0], si_q[1]};

  // ----------------------------------------------------------------
  // register images
  // ----------------------------------------------------------------
  // reserved positions forced low
  assign info_val = {upper_bank_flag, erase_fail, prog_fail, 2'b00,
                     wide_addr, otp_lock, 1'b0};
  assign stat_val = {(otp_mode ? otp_lock : status_guard_bit), status_s6,
                     protect_level_field, write_unlock_latch, busy_flag};
  // accepted status write: latch set, idle, unguarded, 16 bits
  assign wr_ok = cs_rise & state[1] & (bit_cnt == `FAMS_STATUS_WRITE_CMD_BITS)
                 & write_unlock_latch & ~busy_flag & ~hardware_guard_mode;
  // program or erase opcode decoded clears both fail flags
  assign op_start = sclk_rise & cs_low & state[0]
                    & (bit_cnt == `FAMS_OPC_BITS - 5'h01)
                    & ((opc == PROG_OP) | (opc == SECT_ER_OP)
                       | (opc == BLK_ER_OP) | (opc == CHIP_ER_OP));

  // ----------------------------------------------------------------
  // frame decoder
  // ----------------------------------------------------------------
  // one opcode per chip-select frame; data after it per command
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_OPC;
      bit_cnt <= 5'h00;
      shift_in <= 8'h00;
      read_sel <= 8'h00;
      wide_addr <= 1'b0;
      upper_bank_flag <= 1'b0;
    end
    else if (!cs_low)
    begin
      state <= ST_OPC;
      bit_cnt <= 5'h00;
    end
    else if (sclk_rise)
    begin
      shift_in <= opc;
      if (bit_cnt != 5'h1F)
        bit_cnt <= bit_cnt + 5'h01;
      if (state[0] && bit_cnt == `FAMS_OPC_BITS - 5'h01)
      begin
        state <= ST_IGN;
        if (opc == `FAMS_OP_STATUS_WRITE)
          state <= ST_DATA;
        else if (opc == `FAMS_OP_STATUS_READ)
        begin
          state <= ST_READ;
          read_sel <= 8'h00;
        end
        else if (opc == `FAMS_OP_INFO_READ)
        begin
          state <= ST_READ;
          read_sel <= 8'h01;
        end
        else if (opc == `FAMS_OP_WIDE_ENTER)
        begin
          wide_addr <= 1'b1;
          upper_bank_flag <= 1'b0;
        end
        else if (opc == `FAMS_OP_WIDE_EXIT)
          wide_addr <= 1'b0;
        else if (opc == `FAMS_OP_BANK_ENTER)
          upper_bank_flag <= 1'b1;
        else if (opc == `FAMS_OP_BANK_EXIT || opc == QIO_RST_OP)
          upper_bank_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // status register, unlock latch and timed write
  // ----------------------------------------------------------------
  // data byte never touches busy or latch positions
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      write_unlock_latch <= 1'b0;
      busy_flag <= 1'b0;
      tw_cnt <= {CW{1'b0}};
      status_guard_bit <= 1'b0;
      status_s6 <= 1'b0;
      protect_level_field <= 4'h0;
      otp_lock <= 1'b0;
      hardware_guard_mode <= 1'b0;
    end
    else
    begin
      hardware_guard_mode <= status_guard_bit & ~wp_q[1];
      if (busy_flag)
      begin
        // busy for the whole cycle, latch cleared at its end
        if (tw_cnt == TW_LAST)
        begin
          busy_flag <= 1'b0;
          write_unlock_latch <= 1'b0;
          tw_cnt <= {CW{1'b0}};
        end
        else
          tw_cnt <= tw_cnt + {{(CW-1){1'b0}}, 1'b1};
      end
      else if (wr_ok)
      begin
        busy_flag <= 1'b1;
        if (otp_mode)
          otp_lock <= 1'b1; // sealed until reset, data ignored
        else
        begin
          status_guard_bit <= shift_in[`FAMS_ST_GUARD];
          status_s6 <= shift_in[`FAMS_ST_AUX];
          protect_level_field <= shift_in[`FAMS_ST_LEVEL_HI:`FAMS_ST_LEVEL_LO];
        end
      end
      else if (sclk_rise && cs_low && state[0]
               && bit_cnt == `FAMS_OPC_BITS - 5'h01 && !busy_flag)
      begin
        if (opc == `FAMS_OP_UNLOCK)
          write_unlock_latch <= 1'b1;
        else if (opc == `FAMS_OP_RELOCK)
          write_unlock_latch <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // program and erase fail flags
  // ----------------------------------------------------------------
  // a failure in the clearing cycle wins over the clear
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      prog_fail <= 1'b0;
      erase_fail <= 1'b0;
    end
    else
    begin
      if (prog_fail_evt || prog_prot_hit || (prog_otp_hit && otp_lock))
        prog_fail <= 1'b1;
      else if (wr_ok || op_start)
        prog_fail <= 1'b0;
      if (erase_fail_evt || erase_prot_hit || (erase_otp_hit && otp_lock))
        erase_fail <= 1'b1;
      else if (wr_ok || op_start)
        erase_fail <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // serial read-out of status and info registers
  // ----------------------------------------------------------------
  // shifts on falling edges, fresh value every byte, repeats until cs rises
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      so <= 1'b0;
      so_oe <= 1'b0;
      sh_out <= 8'h00;
      rd_cnt <= 3'h0;
    end
    else if (!cs_low || !state[2])
    begin
      so_oe <= 1'b0;
      rd_cnt <= 3'h0;
    end
    else if (sclk_fall)
    begin
      so_oe <= 1'b1;
      rd_cnt <= rd_cnt + 3'h1;
      if (rd_cnt == 3'h0)
      begin
        so <= read_sel[0] ? info_val[7] : stat_val[7];
        sh_out <= {(read_sel[0] ? info_val[6:0] : stat_val[6:0]), 1'b0};
      end
      else
      begin
        so <= sh_out[7];
        sh_out <= {sh_out[6:0], 1'b0};
      end
    end
  end
endmodule // fams_top
`default_nettype wire

//--- shared/fams_consts.vh
// constants of the flash address-mode and status-write command block
`ifndef FAMS_CONSTS_VH
`define FAMS_CONSTS_VH
// opcodes
`define FAMS_OP_STATUS_WRITE 8'h01
`define FAMS_OP_STATUS_READ 8'h05
`define FAMS_OP_UNLOCK 8'h06
`define FAMS_OP_RELOCK 8'h04
`define FAMS_OP_INFO_READ 8'h2B
`define FAMS_OP_WIDE_ENTER 8'hB7
`define FAMS_OP_WIDE_EXIT 8'hE9
`define FAMS_OP_BANK_ENTER 8'h67
`define FAMS_OP_BANK_EXIT 8'h98
// frame bit counts
`define FAMS_OPC_BITS 5'h08
`define FAMS_STATUS_WRITE_CMD_BITS 5'h10
// information register bit positions
`define FAMS_INFO_BANK 7
`define FAMS_INFO_ERASE_FAIL 6
`define FAMS_INFO_PROG_FAIL 5
`define FAMS_INFO_WIDE 2
`define FAMS_INFO_OTP 1
`define FAMS_INFO_RESET 8'h00
// status register positions
`define FAMS_ST_GUARD 7
`define FAMS_ST_LEVEL_HI 5
`define FAMS_ST_LEVEL_LO 2
`define FAMS_ST_AUX 6
`define FAMS_ST_RESET 8'h00
// self-timed status write, in microseconds
`define FAMS_TW_US 10
`define FAMS_MCLK_MHZ 25
`endif

//--- bench/fams_asserts.sv
// checker of the flash command block outputs
`timescale 1ns/100ps
`default_nettype none
module fams_asserts #(
  parameter TW_CYCLES = 250 // write cycle length
) (
  input wire logic mclk, // clock
  input wire logic resetn, // reset
  input wire logic wp_n, // guard pin
  input wire logic busy_flag, // busy
  input wire logic write_unlock_latch, // latch
  input wire logic otp_lock, // otp seal
  input wire logic [3:0] protect_level_field, // level
  input wire logic status_guard_bit, // guard bit
  input wire logic hardware_guard_mode // guard mode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  reg [15:0] busy_cnt;
  // length of the current busy span
  always @(posedge mclk or negedge resetn)
    if (!resetn)
      busy_cnt <= 16'h0000;
    else
      busy_cnt <= busy_flag ? busy_cnt + 16'h0001 : 16'h0000;
  a_busy_span: assert property ($fell(busy_flag) |-> busy_cnt == TW_CYCLES)
    else $error("busy span length wrong");
  a_latch_drop: assert property ($fell(busy_flag) |-> !write_unlock_latch)
    else $error("latch kept after write cycle");
  a_busy_latch: assert property ($rose(busy_flag) |-> write_unlock_latch)
    else $error("write cycle without latch");
  a_field_busy: assert property (
    $changed(protect_level_field) || $changed(status_guard_bit) |-> $rose(busy_flag))
    else $error("status field moved outside write");
  a_guard_block: assert property (hardware_guard_mode [*3] |-> !$rose(busy_flag))
    else $error("write ran in guard mode");
  a_guard_on: assert property ((status_guard_bit && !wp_n) [*5] |-> hardware_guard_mode)
    else $error("guard mode missing");
  a_otp_sticky: assert property (otp_lock |=> otp_lock)
    else $error("otp seal cleared");
  a_otp_write: assert property ($rose(otp_lock) |-> $rose(busy_flag))
    else $error("otp seal set outside write");
endmodule // fams_asserts
`default_nettype wire

//--- bench/fams_host.sv
// host controller model driving the serial pins
`timescale 1ns/100ps
`default_nettype none
module fams_host (
  input wire logic mclk, // block clock
  output var logic cs_n, // chip select
  output var logic sclk, // serial clock
  output var logic si, // serial data out
  input wire logic so // serial data in
);
  // idle pins, clock stands low
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  // wait n clocks, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // one frame of n bits msb first, last 8 so bits returned
  task automatic frame(input [15:0] d, input [4:0] n, output [7:0] rd);
    rd = 8'h00;
    cs_n = 1'b0;
    tick(4);
    for (int i = 0; i < n; i++)
    begin
      si = (i < 16) ? d[15 - i] : 1'b0;
      tick(4);
      sclk = 1'b1;
      tick(4);
      rd = {rd[6:0], so};
      sclk = 1'b0;
    end
    tick(4);
    cs_n = 1'b1;
    si = ~si;
    tick(6);
  endtask
endmodule // fams_host
`default_nettype wire

//--- bench/tb.sv
// testbench of the flash command block
`timescale 1ns/100ps
`default_nettype none
`include "fams_consts.vh"
module tb;
  logic mclk, resetn, wp_n, otp_mode, so, so_oe, busy, latch, wide, bank, otp, guard, hgm;
  logic [3:0] level;
  logic [5:0] evt;
  logic [7:0] rd;
  int bad_count, cmp_count;
  wire logic cs_n, sclk, si;
  fams_top #(.TW_CYCLES(20)) i_dut (.mclk(mclk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk),
    .si(si), .wp_n(wp_n), .otp_mode(otp_mode), .prog_fail_evt(evt[0]),
    .prog_prot_hit(evt[1]), .prog_otp_hit(evt[2]), .erase_fail_evt(evt[3]),
    .erase_prot_hit(evt[4]), .erase_otp_hit(evt[5]), .so(so), .so_oe(so_oe),
    .busy_flag(busy), .write_unlock_latch(latch), .wide_addr(wide), .upper_bank_flag(bank),
    .otp_lock(otp), .protect_level_field(level), .status_guard_bit(guard),
    .hardware_guard_mode(hgm));
  fams_host i_host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so));
  // 25 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // compare and count
  task automatic chk(input [7:0] got, input [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic op(input [7:0] o);
    i_host.frame({o, 8'h00}, 5'd8, rd);
  endtask
  task automatic status_write_cmd(input [7:0] v, input [4:0] n);
    i_host.frame({`FAMS_OP_STATUS_WRITE, v}, n, rd);
  endtask
  task automatic info(output [7:0] v);
    i_host.frame({`FAMS_OP_INFO_READ, 8'h00}, 5'd16, v);
  endtask
  // bounded wait for the write cycle to end
  task automatic idle;
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 100)
    begin
      i_host.tick(1);
      k++;
    end
    chk({6'h00, busy, latch}, 8'h00);
  endtask
  // mode opcodes and the flags they move
  task automatic t_modes;
    logic [7:0] ops [7] = '{8'h67, 8'hB7, 8'h67, 8'h98, 8'h67, 8'hFF, 8'hE9};
    logic [1:0] exp [7] = '{2'h1, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h0};
    for (int i = 0; i < 7; i++)
    begin
      op(ops[i]);
      chk({6'h00, wide, bank}, {6'h00, exp[i]});
      if (i == 2)
      begin
        info(rd);
        chk(rd, 8'h84);
      end
    end
  endtask
  // each fail report sets its flag, next operation clears it; otp hits count only once sealed
  task automatic t_fail;
    logic [7:0] clr [6] = '{8'h02, 8'hD8, 8'h02, 8'hC7, 8'h20, 8'h20};
    for (int i = 0; i < 6; i++)
    begin
      evt[i] = 1'b1;
      i_host.tick(1);
      evt = 6'h00;
      info(rd);
      chk(rd & 8'hE6, (i == 2 || i == 5) ? 8'h00 : (i < 3) ? 8'h20 : 8'h40);
      op(clr[i]);
      info(rd);
      chk(rd, 8'h00);
    end
  endtask
  // status write refusals and a good write
  task automatic t_status;
    status_write_cmd(8'hBF, 5'd16);
    chk({6'h00, busy, latch}, 8'h00);
    op(8'h06);
    chk({7'h00, latch}, 8'h01);
    op(`FAMS_OP_RELOCK);
    chk({7'h00, latch}, 8'h00);
    op(8'h06);
    status_write_cmd(8'hBF, 5'd17);
    chk({7'h00, busy}, 8'h00);
    status_write_cmd(8'hBF, 5'd16);
    chk({1'b0, busy, latch, guard, level}, 8'h7F);
    idle;
    i_host.frame({`FAMS_OP_STATUS_READ, 8'h00}, 5'd16, rd);
    chk(rd, 8'hBC);
  endtask
  // guard pin locks, then frees, the status write
  task automatic t_guard;
    wp_n = 1'b0;
    i_host.tick(5);
    chk({7'h00, hgm}, 8'h01);
    op(8'h06);
    status_write_cmd(8'h00, 5'd16);
    chk({3'h0, busy, level}, 8'h0F);
    wp_n = 1'b1;
    i_host.tick(5);
    status_write_cmd(8'h00, 5'd16);
    chk({2'h0, busy, guard, level}, 8'h20);
    idle;
  endtask
  // sealing the otp sector
  task automatic t_otp;
    otp_mode = 1'b1;
    op(8'h06);
    status_write_cmd(8'h00, 5'd16);
    idle;
    chk({7'h00, otp}, 8'h01);
    info(rd);
    chk(rd, 8'h02);
    i_host.frame({`FAMS_OP_STATUS_READ, 8'h00}, 5'd16, rd);
    chk(rd, 8'h80);
    evt = 6'h24;
    i_host.tick(1);
    evt = 6'h00;
    info(rd);
    chk(rd, 8'h62);
    op(8'h06);
    status_write_cmd(8'h00, 5'd16);
    idle;
    info(rd);
    chk(rd, 8'h02);
  endtask
  // mid-run reset clears every volatile flag
  task automatic t_reset;
    op(8'hB7);
    op(8'h67);
    evt = 6'h09;
    i_host.tick(1);
    evt = 6'h00;
    info(rd);
    chk(rd, 8'hE6);
    resetn = 1'b0;
    i_host.tick(3);
    resetn = 1'b1;
    i_host.tick(3);
    chk({busy, latch, wide, bank, otp, guard, hgm, so_oe}, 8'h00);
    info(rd);
    chk(rd, 8'h00);
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // main sequence
  initial
  begin
    resetn = 1'b0;
    wp_n = 1'b1;
    otp_mode = 1'b0;
    evt = 6'h00;
    bad_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge mclk);
    #1;
    resetn = 1'b1;
    i_host.tick(3);
    chk({busy, latch, wide, bank, otp, guard, hgm, so_oe}, 8'h00);
    info(rd);
    chk(rd, 8'h00);
    t_modes;
    t_fail;
    t_status;
    t_guard;
    t_otp;
    t_reset;
    print_verdict;
  end
  // watchdog
  initial
  begin
    #3000000;
    bad_count++;
    print_verdict;
  end
endmodule // tb
bind fams_top fams_asserts #(.TW_CYCLES(TW_CYCLES)) i_chk (.mclk(mclk), .resetn(resetn),
  .wp_n(wp_n), .busy_flag(busy_flag), .write_unlock_latch(write_unlock_latch),
  .otp_lock(otp_lock), .protect_level_field(protect_level_field),
  .status_guard_bit(status_guard_bit), .hardware_guard_mode(hardware_guard_mode));
`default_nettype wire
